// *** core/sdac_pkg.sv ***
// Package for the serial converter input control block.
// Assumes a single system clock plus the serial clock from the master.
package sdac_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned BIT_CNT_W = 5;
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [4:0] FULL_WORD = 5'h10;
  localparam real SCLK_MAX_MHZ = 50.0;
  localparam real SYS_CLK_MHZ = 250.0;
  // System cycles per fastest serial period, rounded to nearest
  localparam int unsigned SCLK_MIN_CYC = int'(SYS_CLK_MHZ / SCLK_MAX_MHZ);

  // Serial-domain state
  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  bits;
  } link_st_t;

  // System-domain state
  typedef struct packed {
    logic [2:0]  cs_sync;
    logic [2:0]  load_sync;
    logic [1:0]  pd_sync;
    logic [1:0]  rst_sync;
    logic [1:0]  sel_sync;
    logic [15:0] input_reg;
    logic [15:0] dac_reg;
    logic        out_disable;
    logic        frame_done;
  } sys_st_t;

endpackage : sdac_pkg

// *** core/sdac_input_ctrl.sv ***
// Input logic of a 16-bit voltage-output converter: serial port, input
// register, output register, reset and power-down handling.
// Assumes the serial clock is stopped while chip select is high and that
// the shift register is stable at least three system cycles after cs rises.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Falling chip select starts a new frame and enables bit reception.
// - Rising chip select copies the shift register into the input register.
// - Serial clock up to 50 MHz; master never runs faster.
// - Master changes data on falling edge; device samples on rising edge.
// - Words go MSB first; first sampled bit is bit 15.
// - Extra clocks keep only the last 16 bits, last bit as LSB.
// - Low load strobe copies input register to output register anytime.
// - Load held low updates output register at each rising chip select.
// - Active-low reset forces registers to a known state.
// - Reset loads zero when strap low, mid-scale when strap high.
// - Power-down high enters power-down; low returns to normal.
module sdac_input_ctrl (
  // System clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // Serial link from the master
  input  wire logic        I_SCLK,
  input  wire logic        I_CS_N,
  input  wire logic        I_SDI,
  // Control pins
  input  wire logic        I_LOAD_OUTPUT_STROBE_N,
  input  wire logic        I_DEV_RESET_N,
  input  wire logic        I_RESET_VALUE_STRAP,
  input  wire logic        I_POWER_DOWN_REQUEST,
  // Converter side
  output logic [15:0]      O_DAC_CODE,
  output logic [15:0]      O_INPUT_CODE,
  output logic             O_OUTPUT_DISABLE
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial domain

  sdac_pkg::link_st_t link_r;
  sdac_pkg::link_st_t link_nxt;

  always_comb begin
    link_nxt = link_r;
    // Shifting left keeps the newest 16 bits, last one at bit 0
    link_nxt.shift = {link_r.shift[14:0], I_SDI};
    if (link_r.bits != sdac_pkg::FULL_WORD) begin
      link_nxt.bits = link_r.bits + 5'h01;
    end
  end

  // Chip select high clears the bit count, so the next fall starts a frame.
  // Shift data is kept: the system side copies it after cs rises.
  always_ff @(posedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      link_r.bits <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain

  sdac_pkg::sys_st_t st_r;
  sdac_pkg::sys_st_t st_nxt;

  logic cs_rise;
  logic load_active;
  logic load_fall;
  logic dev_reset;
  logic [15:0] reset_code;

  always_comb begin
    // Only stage 1 and later are read by logic
    cs_rise = st_r.cs_sync[1] & ~st_r.cs_sync[2];
    load_active = ~st_r.load_sync[1];
    load_fall = ~st_r.load_sync[1] & st_r.load_sync[2];
    dev_reset = ~st_r.rst_sync[1];
    reset_code = st_r.sel_sync[1] ? sdac_pkg::MID_CODE
                                  : sdac_pkg::ZERO_CODE;
    st_nxt = st_r;
    st_nxt.cs_sync = {st_r.cs_sync[1:0], I_CS_N};
    st_nxt.load_sync = {st_r.load_sync[1:0], I_LOAD_OUTPUT_STROBE_N};
    st_nxt.pd_sync = {st_r.pd_sync[0], I_POWER_DOWN_REQUEST};
    st_nxt.rst_sync = {st_r.rst_sync[0], I_DEV_RESET_N};
    st_nxt.sel_sync = {st_r.sel_sync[0], I_RESET_VALUE_STRAP};
    st_nxt.frame_done = cs_rise;
    // Shift register is quiet once cs is high: safe to sample here
    if (cs_rise) begin
      st_nxt.input_reg = link_r.shift;
    end
    // Level load follows the input register, so a held-low strobe
    // updates right after the input register changes
    if (load_active) begin
      st_nxt.dac_reg = st_r.input_reg;
    end
    if (load_fall && cs_rise) begin
      st_nxt.dac_reg = link_r.shift;
    end
    st_nxt.out_disable = st_r.pd_sync[1];
    if (dev_reset) begin
      st_nxt.input_reg = reset_code;
      st_nxt.dac_reg = reset_code;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_r <= '{cs_sync: 3'h7, load_sync: 3'h7, pd_sync: 2'h0,
                rst_sync: 2'h3, sel_sync: 2'h0,
                input_reg: sdac_pkg::ZERO_CODE,
                dac_reg: sdac_pkg::ZERO_CODE,
                out_disable: 1'b0, frame_done: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: registers kept while powered down

  assign O_DAC_CODE = st_r.dac_reg;
  assign O_INPUT_CODE = st_r.input_reg;
  assign O_OUTPUT_DISABLE = st_r.out_disable;

endmodule : sdac_input_ctrl
`default_nettype wire

// *** test/sdac_monitor.sv ***
// Checker for the converter input block.
// Sees the top ports only; bound after the module.
`timescale 1ns/1ns
`default_nettype none
module sdac_monitor (
  input wire logic        I_CLK, I_RST, I_SCLK, I_CS_N, I_SDI,
  input wire logic        I_LOAD_OUTPUT_STROBE_N, I_DEV_RESET_N,
  input wire logic        I_RESET_VALUE_STRAP, I_POWER_DOWN_REQUEST,
  input wire logic [15:0] O_DAC_CODE, O_INPUT_CODE,
  input wire logic        O_OUTPUT_DISABLE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // Margins cover the synchronisers
  sequence pd_held; I_POWER_DOWN_REQUEST[*4]; endsequence
  sequence rst_mid; (!I_DEV_RESET_N && I_RESET_VALUE_STRAP)[*5]; endsequence
  sequence rst_zero; (!I_DEV_RESET_N && !I_RESET_VALUE_STRAP)[*5]; endsequence
  pd_on_a: assert property (pd_held |-> O_OUTPUT_DISABLE) else $error("pd");
  pd_off_a: assert property ((!I_POWER_DOWN_REQUEST)[*4] |-> !O_OUTPUT_DISABLE) else $error("pd");
  mid_reset_a: assert property (rst_mid |-> O_DAC_CODE == 16'h8000 && O_INPUT_CODE == 16'h8000) else $error("mid");
  zero_reset_a: assert property (rst_zero |-> O_DAC_CODE == 16'h0000 && O_INPUT_CODE == 16'h0000) else $error("zero");
  load_track_a: assert property ((!I_LOAD_OUTPUT_STROBE_N && I_DEV_RESET_N)[*5] |=> O_DAC_CODE == $past(O_INPUT_CODE)) else $error("track");
  load_hold_a: assert property ((I_LOAD_OUTPUT_STROBE_N && I_DEV_RESET_N)[*6] |=> $stable(O_DAC_CODE)) else $error("hold");
  frame_hold_a: assert property ((!I_CS_N && I_DEV_RESET_N)[*8] |=> $stable(O_INPUT_CODE)) else $error("frame");
  idle_hold_a: assert property ((I_CS_N && I_DEV_RESET_N)[*8] |=> $stable(O_INPUT_CODE)) else $error("idle");
endmodule : sdac_monitor
bind sdac_input_ctrl sdac_monitor u_sdac_monitor (.*);
`default_nettype wire

// *** test/sdac_master.sv ***
// Serial master model; 80 ns link clock, idle low.
// The bench calls send; clock stands still outside frames.
`timescale 1ns/1ns
`default_nettype none
module sdac_master (
  output logic O_SCLK,
  output logic O_CS_N,
  output logic O_SDI
);
  initial begin
    O_SCLK = 0;
    O_CS_N = 1;
    O_SDI = 0;
  end
  task automatic send(input logic [19:0] w, input int n);
    O_CS_N = 0;
    for (int i = n - 1; i >= 0; i--) begin
      O_SDI = w[i];
      #40 O_SCLK = 1;
      #40 O_SCLK = 0;
    end
    O_CS_N = 1;
    O_SDI = ~O_SDI; // Last bit inverted: no stale value
  endtask : send
endmodule : sdac_master
`default_nettype wire

// *** test/test_sdac_input_ctrl.sv ***
// Bench for the converter input block.
// Expects sdac_master and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t %h %h", $time, a, b); end end
module test_sdac_input_ctrl;
  logic clk = 0, rst = 1, load_n = 1, drst_n = 1, strap = 0, pd = 0;
  wire logic sclk, cs_n, sdi, dis;
  logic [15:0] dac, inc, e, prev, d, q[$];
  logic [19:0] w;
  int errors = 0, checks_done = 0;
  always #2 clk = ~clk;
  sdac_master u_sdac_master (.O_SCLK(sclk), .O_CS_N(cs_n), .O_SDI(sdi));
  sdac_input_ctrl u_sdac_input_ctrl (.I_CLK(clk), .I_RST(rst),
    .I_SCLK(sclk), .I_CS_N(cs_n), .I_SDI(sdi),
    .I_LOAD_OUTPUT_STROBE_N(load_n), .I_DEV_RESET_N(drst_n),
    .I_RESET_VALUE_STRAP(strap), .I_POWER_DOWN_REQUEST(pd),
    .O_DAC_CODE(dac), .O_INPUT_CODE(inc), .O_OUTPUT_DISABLE(dis));
  task end_of_test;
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // Each change of the input code takes the oldest note
  always @(inc) if (!rst) begin
    e = q.pop_front();
    `CHK(inc, e)
  end
  // Flipped LSB makes every new word visible as a change
  task automatic frame(input int n);
    w = 20'($urandom);
    w[0] = ~prev[0];
    q.push_back(w[15:0]);
    prev = w[15:0];
    if (!load_n) d = w[15:0];
    u_sdac_master.send(w, n);
    repeat (8) @(negedge clk);
    `CHK(dac, d)
    `CHK(dis, pd)
  endtask : frame
  initial begin
    void'($urandom(32'hee1212c1));
    prev = 0;
    d = 0;
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) load_n = 1'(i);
      pd = 1'(i >> 1);
      frame(i == 3 ? 20 : 16);
    end
    for (int s = 1; s >= 0; s--) begin
      @(negedge clk) strap = 1'(s);
      drst_n = 0;
      q.push_back(s ? sdac_pkg::MID_CODE : sdac_pkg::ZERO_CODE);
      repeat (8) @(negedge clk);
      d = s ? sdac_pkg::MID_CODE : sdac_pkg::ZERO_CODE;
      `CHK(dac, d)
      drst_n = 1;
      repeat (4) @(negedge clk);
    end
    prev = 0;
    load_n = 0;
    frame(16);
    end_of_test();
  end
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule : test_sdac_input_ctrl
`default_nettype wire
